// File: include/rf_cfg_pkg.sv
// Types shared by the RF front-end configuration writer.
// Assumes rf_cfg_regs.svh on the include path.
`include "rf_cfg_regs.svh"
package rf_cfg_pkg;
    typedef struct packed {
        logic [`DATA_BITS-1:0] data;
        logic [`ADDR_BITS-1:0] addr;
    } cfg_frame_s;

    typedef struct packed {
        logic       valid;
        logic [1:0] bits;
    } if_sample_s;

    typedef enum logic [1:0] {
        ST_GAP,
        ST_SHIFT,
        ST_DONE
    } cfg_state_e;
endpackage

// File: include/rf_cfg_regs.svh
// Constants for the RF front-end configuration writer.
// Included by the package and the design; definitions only.
`ifndef RF_CFG_REGS_SVH
`define RF_CFG_REGS_SVH

`define CLK_PERIOD_NS     25
`define FRAME_GAP_NS      4000000
`define FRAME_GAP_CYC     (`FRAME_GAP_NS / `CLK_PERIOD_NS)
`define DATA_BITS         28
`define ADDR_BITS         4
`define FRAME_BITS        32
`define NUM_USED_REGS     8
`define LAST_REG_IDX      3'h7
`define LAST_BIT_IDX      5'h1f

`define CFG_VAL_0         28'ha295563
`define CFG_VAL_1         28'h0550288
`define CFG_VAL_2         28'hd6fe1dc
`define CFG_VAL_3         28'h9cc0000
`define CFG_VAL_4         28'h0180010
`define CFG_VAL_5         28'h0fe0070
`define CFG_VAL_6         28'h8000000
`define CFG_VAL_7         28'h10061b2

`endif

// File: src/rf_frontend_config_writer.sv
// Programs the RF front-end over its three-wire serial port after reset,
// drives the RF routing switch and forwards every second digitised IF sample to storage.
// Assumes the front-end sample clock is a separate, free-running domain.
//
// Operation
// RULE_01: Each frame carries a 28-bit data word, most significant bit first.
// RULE_02: Each frame carries a 4-bit register address field.
// RULE_03: Chip select goes low before a frame's first bit.
// RULE_04: Data bit is stable at each rising serial clock edge.
// RULE_05: Chip select returns high after exactly 32 clocked bits.
// RULE_06: Only registers zero to seven are written; test registers never.
// RULE_07: Frames start 4 ms apart.
// RULE_08: Each register sent once per reset, then no more traffic.
// RULE_09: Address 0000 gets A295563.
// RULE_10: Address 0001 gets 0550288.
// RULE_11: Address 0010 gets D6FE1DC.
// RULE_12: Address 0011 gets 9CC0000.
// RULE_13: Addresses 0100 and 0101 get 0180010 and 0FE0070.
// RULE_14: Addresses 0110 and 0111 get 8000000 and 10061B2.
// RULE_15: Controller drives the RF switch select.
// RULE_16: After parachute deployment, route antenna to position receiver.
// RULE_17: Accept digitised IF samples and pass them to non-volatile storage. Only every second sample is passed on.
// RULE_18: Data bits go first, then address bits, MSB first.
// RULE_19: Idle and reset: chip select high, clock low; data changes on falls.
// RULE_20: Ascending address order; a flag shows all eight frames done.
`timescale 1ns/10ps
`include "rf_cfg_regs.svh"

module rf_frontend_config_writer #(
    // Frame spacing in system clocks; the default is the 4 ms period
    parameter int GAP_CYC = `FRAME_GAP_CYC
) (
    input  wire logic                   CLK_I,
    input  wire logic                   RSTN_I,
    input  wire logic                   IF_CLK_I,
    input  wire logic [1:0]             IF_SAMPLE_I,
    input  wire logic                   CHUTE_DEPLOYED_I,
    output logic                        CFG_CS_N_O,
    output logic                        CFG_SCLK_O,
    output logic                        CONFIG_SERIAL_LINE_O,
    output logic                        CFG_DONE_O,
    output logic                        RF_SW_TO_RECEIVER_O,
    output rf_cfg_pkg::if_sample_s      STORE_SAMPLE_O
);
    import rf_cfg_pkg::*;

    cfg_state_e                 state_r;
    logic [21:0]                gap_cnt_r;
    logic [2:0]                 reg_idx_r;
    logic [4:0]                 bit_idx_r;
    logic                       phase_r;
    logic [`FRAME_BITS-1:0]     shift_r;
    logic                       cs_n_r;
    logic                       sclk_r;
    logic                       done_r;
    logic                       chute_s_r;
    logic                       sw_r;
    cfg_frame_s                 frame_nxt;
    logic                       gap_end;
    logic                       frame_start;
    logic                       bit_fall;
    logic                       last_bit;
    logic                       last_reg;
    logic                       frame_end;

    localparam logic [21:0] GAP_LAST = 22'(GAP_CYC - 1);

    // Fixed table; indices 8 and 9 are test registers and are unreachable
    always_comb begin
        frame_nxt.addr = {1'b0, reg_idx_r}; // RULE_02 RULE_06
        case (reg_idx_r)
            3'h0:    frame_nxt.data = `CFG_VAL_0; // RULE_09
            3'h1:    frame_nxt.data = `CFG_VAL_1; // RULE_10
            3'h2:    frame_nxt.data = `CFG_VAL_2; // RULE_11
            3'h3:    frame_nxt.data = `CFG_VAL_3; // RULE_12
            3'h4:    frame_nxt.data = `CFG_VAL_4; // RULE_13
            3'h5:    frame_nxt.data = `CFG_VAL_5; // RULE_13
            3'h6:    frame_nxt.data = `CFG_VAL_6; // RULE_14
            3'h7:    frame_nxt.data = `CFG_VAL_7; // RULE_14
            default: frame_nxt.data = `CFG_VAL_0;
        endcase
    end

    assign gap_end     = (gap_cnt_r == GAP_LAST);
    assign frame_start = (state_r == ST_GAP) && gap_end;
    // Data moves when the serial clock falls, at the end of each bit's high half
    assign bit_fall    = (state_r == ST_SHIFT) && phase_r;
    assign last_bit    = (bit_idx_r == `LAST_BIT_IDX);
    assign last_reg    = (reg_idx_r == `LAST_REG_IDX);
    assign frame_end   = bit_fall && last_bit; // RULE_05

    // Frame period counter: frames start every 4 ms from the first start
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gap_cnt_r <= 22'h0;
        end else if (state_r == ST_DONE || gap_end) begin
            gap_cnt_r <= 22'h0; // RULE_07
        end else begin
            gap_cnt_r <= gap_cnt_r + 22'h1;
        end
    end

    // Sequencer; the first frame waits one full period so the front-end is powered
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= ST_GAP;
        end else begin
            case (state_r)
                ST_GAP: begin
                    if (frame_start) begin
                        state_r <= ST_SHIFT; // RULE_07
                    end
                end
                ST_SHIFT: begin
                    if (frame_end) begin
                        // Nothing restarts the table short of a reset
                        state_r <= last_reg ? ST_DONE : ST_GAP; // RULE_08
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE; // RULE_08
                end
                default: begin
                    state_r <= ST_GAP;
                end
            endcase
        end
    end

    // Register index only climbs, so addresses 8 and 9 can never be reached
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            reg_idx_r <= 3'h0;
        end else if (frame_end && !last_reg) begin
            reg_idx_r <= reg_idx_r + 3'h1; // RULE_20
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bit_idx_r <= 5'h0;
        end else if (frame_start) begin
            bit_idx_r <= 5'h0;
        end else if (bit_fall && !last_bit) begin
            bit_idx_r <= bit_idx_r + 5'h1; // RULE_05
        end
    end

    // Bit phase: low half then high half of each serial clock period
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            phase_r <= 1'b0;
        end else if (frame_start) begin
            phase_r <= 1'b0;
        end else if (state_r == ST_SHIFT) begin
            phase_r <= ~phase_r; // RULE_04
        end
    end

    // Frame shifter: data word in the upper bits, address below
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            shift_r <= '0;
        end else if (frame_start) begin
            shift_r <= frame_nxt; // RULE_18
        end else if (bit_fall) begin
            shift_r <= {shift_r[`FRAME_BITS-2:0], 1'b0}; // RULE_01 RULE_19
        end
    end

    // Serial pins registered; one bit spans two system clocks (20 MHz SCLK)
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cs_n_r <= 1'b1; // RULE_19
        end else begin
            cs_n_r <= (state_r != ST_SHIFT); // RULE_03 RULE_05
        end
    end

    // Clock lags select by one system clock, so select always leads the first rise
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sclk_r <= 1'b0; // RULE_19
        end else begin
            sclk_r <= bit_fall; // RULE_04
        end
    end

    // Data is one clock ahead of SCLK rising, so it is settled at the edge
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            CONFIG_SERIAL_LINE_O <= 1'b0;
        end else begin
            if (state_r == ST_SHIFT) begin
                CONFIG_SERIAL_LINE_O <= shift_r[`FRAME_BITS-1]; // RULE_04
            end else begin
                CONFIG_SERIAL_LINE_O <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == ST_DONE); // RULE_20
        end
    end

    // Deployment input is asynchronous; two flops, and the switch latches once set
    sync_2ff u_chute_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    (CHUTE_DEPLOYED_I),
        .q_o    (chute_s_r)
    );

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sw_r <= 1'b0;
        end else if (chute_s_r) begin
            sw_r <= 1'b1; // RULE_15 RULE_16
        end
    end

    assign CFG_CS_N_O          = cs_n_r;
    assign CFG_SCLK_O          = sclk_r;
    assign CFG_DONE_O          = done_r;
    assign RF_SW_TO_RECEIVER_O = sw_r;

    // IF samples: captured on the link clock, passed across by toggle + handshake-free
    // word hold. The word is stable for two link cycles around each toggle.
    logic [1:0] if_cap_r;
    logic       if_tgl_r;
    logic [1:0] if_a_r;
    logic       t_s_r;
    logic       t_d_r;

    always_ff @(posedge IF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            if_a_r <= 2'h0;
        end else begin
            if_a_r <= IF_SAMPLE_I;
        end
    end

    always_ff @(posedge IF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            if_tgl_r <= 1'b0;
        end else begin
            if_tgl_r <= ~if_tgl_r;
        end
    end

    // Capture on the toggle's fall, so the reset value of if_a_r is never published
    always_ff @(posedge IF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            if_cap_r <= 2'h0;
        end else if (if_tgl_r) begin
            if_cap_r <= if_a_r; // RULE_17
        end
    end

    // Toggle crosses through two flops; the captured word is held two link periods
    sync_2ff u_tgl_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    (if_tgl_r),
        .q_o    (t_s_r)
    );

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            t_d_r          <= 1'b0;
            STORE_SAMPLE_O <= '0;
        end else begin
            t_d_r                <= t_s_r;
            STORE_SAMPLE_O.valid <= ~t_s_r & t_d_r; // RULE_17
            if (~t_s_r & t_d_r) begin
                STORE_SAMPLE_O.bits <= if_cap_r;
            end
        end
    end
endmodule

// Two-flop synchroniser for one level; only the second flop is read outside
module sync_2ff (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    input  wire logic   d_i,
    output logic        q_o
);
    logic meta_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// File: tb/rf_cfg_checker.sv
// Pin assertions for the config writer.
// Assumes all watched pins are in the CLK_I domain.
`timescale 1ns/10ps
module rf_cfg_checker (
    input wire logic             CLK_I,
    input wire logic             RSTN_I,
    input wire logic             CHUTE_DEPLOYED_I,
    input wire logic             CFG_CS_N_O,
    input wire logic             CFG_SCLK_O,
    input wire logic             CONFIG_SERIAL_LINE_O,
    input wire logic             CFG_DONE_O,
    input wire logic             RF_SW_TO_RECEIVER_O,
    input wire rf_cfg_pkg::if_sample_s STORE_SAMPLE_O
);
    import rf_cfg_pkg::*;
    logic [5:0] hi_cnt_r;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Counts SCLK high cycles within the current frame
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) hi_cnt_r <= 6'h0;
        else if (CFG_CS_N_O) hi_cnt_r <= 6'h0;
        else if (CFG_SCLK_O) hi_cnt_r <= hi_cnt_r + 6'h1;
    end
    sequence sclk_pulse_seq;
        CFG_SCLK_O ##1 !CFG_SCLK_O;
    endsequence
    sequence frame_open_seq;
        !CFG_SCLK_O ##1 CFG_SCLK_O;
    endsequence
    chk_idle_clk_low: assert property (CFG_CS_N_O |-> !CFG_SCLK_O)
        else $error("clock high while idle");
    chk_sclk_pulse: assert property ($rose(CFG_SCLK_O) |-> sclk_pulse_seq)
        else $error("clock high too long");
    chk_data_at_rise: assert property ($rose(CFG_SCLK_O) |-> $stable(CONFIG_SERIAL_LINE_O))
        else $error("data moved at clock rise");
    chk_frame_bits: assert property ($rose(CFG_CS_N_O) |-> hi_cnt_r == 6'd32)
        else $error("frame bit count wrong");
    chk_cs_first: assert property ($fell(CFG_CS_N_O) |-> frame_open_seq)
        else $error("select not ahead of clock");
    chk_done_quiet: assert property (CFG_DONE_O |=> CFG_DONE_O && CFG_CS_N_O)
        else $error("traffic after done");
    chk_switch_time: assert property ($rose(CHUTE_DEPLOYED_I) |-> ##[1:3] RF_SW_TO_RECEIVER_O)
        else $error("switch late");
    chk_sample_pulse: assert property (STORE_SAMPLE_O.valid |=> !STORE_SAMPLE_O.valid)
        else $error("sample valid too long");
endmodule
bind rf_frontend_config_writer rf_cfg_checker u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .CHUTE_DEPLOYED_I(CHUTE_DEPLOYED_I), .CFG_CS_N_O(CFG_CS_N_O), .CFG_SCLK_O(CFG_SCLK_O),
    .CONFIG_SERIAL_LINE_O(CONFIG_SERIAL_LINE_O), .CFG_DONE_O(CFG_DONE_O),
    .RF_SW_TO_RECEIVER_O(RF_SW_TO_RECEIVER_O), .STORE_SAMPLE_O(STORE_SAMPLE_O));

// File: tb/rf_fe_model.sv
// Front-end stand-in: serial config slave and IF sample source.
// Assumes the writer is the only master on the serial lines.
`timescale 1ns/10ps
module rf_fe_model (
    input  wire logic   cs_n_i,
    input  wire logic   sclk_i,
    input  wire logic   config_serial_line_i,
    output logic        if_clk_o,
    output logic [1:0]  if_sample_o,
    output logic [1:0]  prev_sample_o,
    output logic [31:0] word_o,
    output int          bits_o,
    output int          frames_o
);
    logic [31:0] shreg = 32'h0;
    int          nbits = 0;
    int          ticks = 0;
    int          seed = 32'h1de64166;
    initial begin
        {if_clk_o, if_sample_o, prev_sample_o, word_o} = '0;
        bits_o = 0;
        frames_o = 0;
        #7;
        forever #32 if_clk_o = ~if_clk_o;
    end
    // Held 16 periods so whichever sample the writer keeps is predictable
    always @(negedge if_clk_o) begin
        ticks++;
        if (ticks % 16 == 0) begin
            prev_sample_o <= if_sample_o;
            if_sample_o <= 2'($random(seed));
        end
    end
    always @(negedge cs_n_i) nbits <= 0;
    always @(posedge sclk_i) if (!cs_n_i) begin
        shreg <= {shreg[30:0], config_serial_line_i};
        nbits <= nbits + 1;
    end
    always @(posedge cs_n_i) if (nbits > 0) begin
        word_o <= shreg;
        bits_o <= nbits;
        frames_o <= frames_o + 1;
    end
endmodule

// File: tb/tb.sv
// Bench: frame contents, spacing, switch and samples.
// Shortens the writer's frame gap by parameter so two reset runs fit the run time.
`timescale 1ns/10ps
module tb;
    import rf_cfg_pkg::*;
    logic        CLK_I = 1'b0;
    logic        RSTN_I = 1'b0;
    logic        CHUTE_DEPLOYED_I = 1'b0;
    logic        IF_CLK_I, CFG_CS_N_O, CFG_SCLK_O, CONFIG_SERIAL_LINE_O;
    logic        CFG_DONE_O, RF_SW_TO_RECEIVER_O;
    logic [1:0]  IF_SAMPLE_I, prev_smp;
    if_sample_s  STORE_SAMPLE_O;
    logic [31:0] fe_word;
    cfg_frame_s  exp_q[$];
    localparam int TB_GAP_CYC  = 1000;
    localparam int TIMEOUT_CYC = 40000;
    int          fe_bits, fe_frames, err_total = 0, checks_done = 0, cyc = 0, starts = 0;
    int          smp_cnt = 0;
    time         t_last;
    logic [27:0] vals [8] = '{28'ha295563, 28'h0550288, 28'hd6fe1dc, 28'h9cc0000,
                             28'h0180010, 28'h0fe0070, 28'h8000000, 28'h10061b2};
    initial forever #12.5 CLK_I = ~CLK_I;
    rf_frontend_config_writer #(.GAP_CYC(TB_GAP_CYC)) DUT (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
        .IF_CLK_I(IF_CLK_I),
        .IF_SAMPLE_I(IF_SAMPLE_I), .CHUTE_DEPLOYED_I(CHUTE_DEPLOYED_I), .CFG_CS_N_O(CFG_CS_N_O),
        .CFG_SCLK_O(CFG_SCLK_O), .CONFIG_SERIAL_LINE_O(CONFIG_SERIAL_LINE_O),
        .CFG_DONE_O(CFG_DONE_O), .RF_SW_TO_RECEIVER_O(RF_SW_TO_RECEIVER_O),
        .STORE_SAMPLE_O(STORE_SAMPLE_O));
    rf_fe_model fe_u (.cs_n_i(CFG_CS_N_O), .sclk_i(CFG_SCLK_O), .config_serial_line_i(CONFIG_SERIAL_LINE_O),
        .if_clk_o(IF_CLK_I), .if_sample_o(IF_SAMPLE_I), .prev_sample_o(prev_smp),
        .word_o(fe_word), .bits_o(fe_bits), .frames_o(fe_frames));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == TIMEOUT_CYC) begin
            err_total++;
            final_report;
        end
    end
    always @(negedge CFG_CS_N_O) if (RSTN_I) begin
        if (starts % 8 > 0) chk(32'($time - t_last), 32'(TB_GAP_CYC * 25));
        t_last = $time;
        starts++;
    end
    always @(fe_frames) if (fe_frames > 0) begin
        chk(fe_bits, 32);
        chk(fe_word, exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hx);
    end
    always @(negedge CLK_I) if (STORE_SAMPLE_O.valid === 1'b1) begin
        smp_cnt++;
        chk(STORE_SAMPLE_O.bits === IF_SAMPLE_I || STORE_SAMPLE_O.bits === prev_smp, 1);
    end
    initial begin
        for (int run = 0; run < 2; run++) begin
            for (int k = 0; k < 8; k++) exp_q.push_back({vals[k], 4'(k)});
            repeat (20) @(negedge CLK_I);
            chk({CFG_CS_N_O, CFG_SCLK_O, CFG_DONE_O, RF_SW_TO_RECEIVER_O}, 4'b1000);
            RSTN_I <= 1'b1;
            @(negedge CLK_I) chk({CFG_CS_N_O, CFG_SCLK_O, CFG_DONE_O}, 3'b100);
            wait (fe_frames == 8 * run + 4);
            @(negedge CLK_I) chk(RF_SW_TO_RECEIVER_O, 0);
            CHUTE_DEPLOYED_I <= 1'b1;
            repeat (4) @(negedge CLK_I);
            chk(RF_SW_TO_RECEIVER_O, 1);
            CHUTE_DEPLOYED_I <= 1'b0;
            $display("test switch %0d done", run);
            wait (CFG_DONE_O === 1'b1);
            @(negedge CLK_I) chk(fe_frames, 8 * run + 8);
            repeat (2 * TB_GAP_CYC) @(negedge CLK_I);
            chk(fe_frames, 8 * run + 8);
            chk(exp_q.size(), 0);
            chk({CFG_DONE_O, CFG_CS_N_O, RF_SW_TO_RECEIVER_O}, 3'b111);
            $display("test frames %0d done", run);
            RSTN_I <= 1'b0;
        end
        chk(smp_cnt > 0, 1);
        final_report;
    end
endmodule
